// ---- src/cog_pkg.sv ----
package cog_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [3:0]  OFFSET_TRIM_IDX     = 4'h2;
    localparam logic [3:0]  GAIN_TRIM_IDX       = 4'h3;
    localparam logic [5:0]  OFFSET_TRIM_ADDR    = {OFFSET_TRIM_IDX, 2'b00};
    localparam logic [5:0]  GAIN_TRIM_ADDR      = {GAIN_TRIM_IDX, 2'b00};
    localparam logic [5:0]  TRIM_STATUS_ADDR    = 6'h10;
    // field positions
    localparam int          OFS_MAG_MSB         = 15;
    localparam int          OFS_MAG_LSB         = 8;
    localparam int          OFS_SIGN_BIT        = 7;
    localparam int          GAIN_MSB            = 15;
    localparam int          GAIN_LSB            = 7;
    // reset values
    localparam logic [15:0] OFFSET_TRIM_RST     = 16'h007F;
    localparam logic [15:0] GAIN_TRIM_RST       = 16'h807F;
    // bus answers
    localparam logic [1:0]  RESP_OKAY           = 2'h0;
    localparam logic [1:0]  RESP_SLVERR         = 2'h2;
endpackage

// ---- src/cog_trim_regs.sv ----
`timescale 1ns/100ps
// How it works
// [R1] Bits 15..8 of the offset register drive the offset magnitude trim code straight out.
// [R2] Code 00h means zero offset and FFh the largest, so the code passes unaltered.
// [R3] Bit 7 of the offset register drives the offset polarity, zero positive, one negative.
// [R4] Reset clears offset magnitude and polarity so no offset is applied until written.
// [R5] Bits 15..7 of the full-scale register drive the 9-bit gain trim code straight out.
// [R6] Gain codes pass unaltered so zeros, 100000000b and all ones map to low, mid and high.
// [R7] Reset loads the gain code 100000000b, which means no gain adjustment.
// [R8] Software should keep the gain code in the narrower recommended band.
// [R9] A gain write takes effect on the outputs at once with no recalibration request.
// [R10] Software writes ones into bits 6..0 of both registers; they have no function.
// [R11] Both trim registers are write-only and read back as an error response.
module cog_trim_regs
    import cog_pkg::*;
(
    input  wire logic        CLK_IN,            // 125 MHz clock
    input  wire logic        RESET_N_IN,        // sync reset, active low
    input  wire logic [5:0]  AWADDR_IN,         // write address
    input  wire logic        AWVALID_IN,        // write address valid
    output logic             AWREADY_OUT,       // write address ready
    input  wire logic [31:0] WDATA_IN,          // write data
    input  wire logic [3:0]  WSTRB_IN,          // write byte strobes
    input  wire logic        WVALID_IN,         // write data valid
    output logic             WREADY_OUT,        // write data ready
    output logic [1:0]       BRESP_OUT,         // write response
    output logic             BVALID_OUT,        // write response valid
    input  wire logic        BREADY_IN,         // write response ready
    input  wire logic [5:0]  ARADDR_IN,         // read address
    input  wire logic        ARVALID_IN,        // read address valid
    output logic             ARREADY_OUT,       // read address ready
    output logic [31:0]      RDATA_OUT,         // read data
    output logic [1:0]       RRESP_OUT,         // read response
    output logic             RVALID_OUT,        // read data valid
    input  wire logic        RREADY_IN,         // read data ready
    output logic [7:0]       OFFSET_MAG_OUT,    // offset magnitude trim code
    output logic             OFFSET_NEG_OUT,    // offset polarity, 1 = negative
    output logic [8:0]       GAIN_CODE_OUT      // full-scale trim code
);
    logic        aw_held_reg;
    logic [5:0]  aw_addr_reg;
    logic        w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic [15:0] offset_trim_reg;
    logic [15:0] gain_trim_reg;
    logic        do_write;
    logic        wr_hit_ofs;
    logic        wr_hit_gain;

    // address and data accepted independently, held until the response leaves
    assign AWREADY_OUT = !aw_held_reg && !bvalid_reg;
    assign WREADY_OUT  = !w_held_reg && !bvalid_reg;
    assign ARREADY_OUT = !rvalid_reg;
    assign BVALID_OUT  = bvalid_reg;
    assign BRESP_OUT   = bresp_reg;
    assign RVALID_OUT  = rvalid_reg;
    assign RDATA_OUT   = rdata_reg;
    assign RRESP_OUT   = rresp_reg;

    // write commits once both halves are held
    assign do_write    = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_hit_ofs  = do_write && (aw_addr_reg == OFFSET_TRIM_ADDR);
    assign wr_hit_gain = do_write && (aw_addr_reg == GAIN_TRIM_ADDR);

    // write address capture
    always_ff @(posedge CLK_IN)
    begin
        if (!RESET_N_IN)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 6'h00;
        end
        else if (AWVALID_IN && AWREADY_OUT)
        begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= {AWADDR_IN[5:2], 2'b00};
        end
        else if (do_write)
        begin
            aw_held_reg <= 1'b0;
        end
    end

    // write data capture
    always_ff @(posedge CLK_IN)
    begin
        if (!RESET_N_IN)
        begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end
        else if (WVALID_IN && WREADY_OUT)
        begin
            w_held_reg <= 1'b1;
            w_data_reg <= WDATA_IN;
            w_strb_reg <= WSTRB_IN;
        end
        else if (do_write)
        begin
            w_held_reg <= 1'b0;
        end
    end

    // write response; unmapped addresses answer with an error
    always_ff @(posedge CLK_IN)
    begin
        if (!RESET_N_IN)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wr_hit_ofs || wr_hit_gain) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (BREADY_IN)
        begin
            bvalid_reg <= 1'b0;
        end
    end

    // trim registers, byte lanes honoured, reset to no correction
    always_ff @(posedge CLK_IN)
    begin
        if (!RESET_N_IN)
        begin
            offset_trim_reg <= OFFSET_TRIM_RST;                 // [R4]
            gain_trim_reg   <= GAIN_TRIM_RST;                   // [R7]
        end
        else
        begin
            if (wr_hit_ofs && w_strb_reg[0])
                offset_trim_reg[7:0] <= w_data_reg[7:0];
            if (wr_hit_ofs && w_strb_reg[1])
                offset_trim_reg[15:8] <= w_data_reg[15:8];
            if (wr_hit_gain && w_strb_reg[0])
                gain_trim_reg[7:0] <= w_data_reg[7:0];          // [R9]
            if (wr_hit_gain && w_strb_reg[1])
                gain_trim_reg[15:8] <= w_data_reg[15:8];        // [R9]
        end
    end

    // trim codes to the analog side, taken unaltered from the fields
    assign OFFSET_MAG_OUT = offset_trim_reg[OFS_MAG_MSB:OFS_MAG_LSB];  // [R1] [R2]
    assign OFFSET_NEG_OUT = offset_trim_reg[OFS_SIGN_BIT];            // [R3]
    assign GAIN_CODE_OUT  = gain_trim_reg[GAIN_MSB:GAIN_LSB];         // [R5] [R6]

    // read channel: trims are write-only, status word shows live codes
    always_ff @(posedge CLK_IN)
    begin
        if (!RESET_N_IN)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end
        else if (ARVALID_IN && ARREADY_OUT)
        begin
            rvalid_reg <= 1'b1;
            if ({ARADDR_IN[5:2], 2'b00} == TRIM_STATUS_ADDR)
            begin
                rdata_reg <= {7'h00, GAIN_CODE_OUT, 7'h00, OFFSET_NEG_OUT,
                              OFFSET_MAG_OUT};
                rresp_reg <= RESP_OKAY;
            end
            else
            begin
                rdata_reg <= 32'h0000_0000;
                rresp_reg <= RESP_SLVERR;                       // [R11]
            end
        end
        else if (RREADY_IN)
        begin
            rvalid_reg <= 1'b0;
        end
    end

    // checks
    sequence ofs_write_s;
        wr_hit_ofs && w_strb_reg[1];
    endsequence

    sequence gain_write_s;
        wr_hit_gain && (w_strb_reg[1:0] == 2'h3);
    endsequence

    reset_offset_a: assert property (@(posedge CLK_IN)           // [R4]
        !RESET_N_IN |=> (OFFSET_MAG_OUT == 8'h00) && !OFFSET_NEG_OUT)
        else $error("offset not cleared by reset");
    reset_gain_a: assert property (@(posedge CLK_IN)             // [R7]
        !RESET_N_IN |=> GAIN_CODE_OUT == 9'h100)
        else $error("gain not mid after reset");
    offset_mag_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // [R1]
        ofs_write_s |=> OFFSET_MAG_OUT == $past(w_data_reg[15:8]))
        else $error("offset magnitude not taken from bits 15:8");
    offset_sign_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // [R3]
        wr_hit_ofs && w_strb_reg[0] |=> OFFSET_NEG_OUT == $past(w_data_reg[7]))
        else $error("offset polarity not taken from bit 7");
    gain_code_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // [R5]
        wr_hit_gain && (w_strb_reg[1:0] == 2'h3)
        |=> GAIN_CODE_OUT == $past(w_data_reg[15:7]))
        else $error("gain code not taken from bits 15:7");
    gain_prompt_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // [R9]
        gain_write_s
        |=> BVALID_OUT && (GAIN_CODE_OUT == $past(w_data_reg[15:7])))
        else $error("gain code not live when the write response rises");
    trims_stable_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // [R2]
        !do_write |=> $stable(OFFSET_MAG_OUT) && $stable(OFFSET_NEG_OUT)
                      && $stable(GAIN_CODE_OUT))
        else $error("trim code moved without a write");
    read_refused_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // [R11]
        ARVALID_IN && ARREADY_OUT && ((ARADDR_IN[5:2] == GAIN_TRIM_IDX)
                                      || (ARADDR_IN[5:2] == OFFSET_TRIM_IDX))
        |=> RVALID_OUT && (RRESP_OUT == RESP_SLVERR))
        else $error("write-only register answered a read");
    offset_lane_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // [R1]
        wr_hit_ofs && !w_strb_reg[1] |=> $stable(OFFSET_MAG_OUT))
        else $error("offset magnitude moved without its byte lane");
    sign_hold_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN) // [R3]
        wr_hit_ofs && !w_strb_reg[0] |=> $stable(OFFSET_NEG_OUT))
        else $error("offset polarity moved without its byte lane");
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module tb_top;
    import cog_pkg::*;
    logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [5:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, rdv;
    logic [3:0]  ws = 4'hF;
    logic [1:0]  br, rr, rsp;
    logic        awr, wr, bv, arr, rv, neg;
    logic [7:0]  mag;
    logic [8:0]  gain;
    logic [15:0] ofs_e = OFFSET_TRIM_RST, gn_e = GAIN_TRIM_RST;
    int          fails = 0, checked = 0;
    // clock at 125 MHz
    always #4 clk = ~clk;
    cog_trim_regs i_cog_trim_regs (.CLK_IN(clk), .RESET_N_IN(rst_n), .AWADDR_IN(awa),
        .AWVALID_IN(awv), .AWREADY_OUT(awr), .WDATA_IN(wd), .WSTRB_IN(ws), .WVALID_IN(wv),
        .WREADY_OUT(wr), .BRESP_OUT(br), .BVALID_OUT(bv), .BREADY_IN(bry), .ARADDR_IN(ara),
        .ARVALID_IN(arv), .ARREADY_OUT(arr), .RDATA_OUT(rd), .RRESP_OUT(rr),
        .RVALID_OUT(rv), .RREADY_IN(rry), .OFFSET_MAG_OUT(mag), .OFFSET_NEG_OUT(neg),
        .GAIN_CODE_OUT(gain));
    // bus write; handshakes judged from values settled before each edge
    task automatic wr_reg(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        bit ta, tw, tb;
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        ws <= s;
        forever
        begin
            @(negedge clk);
            ta = awv & awr; tw = wv & wr; tb = bv; rsp = br;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb)
            begin
                bry <= 1'b0;
                @(negedge clk);
                return;
            end
        end
    endtask
    // bus read
    task automatic rd_reg(input logic [5:0] a);
        bit ta, tr;
        @(posedge clk);
        ara <= a; arv <= 1'b1; rry <= 1'b1;
        forever
        begin
            @(negedge clk);
            ta = arv & arr; tr = rv; rsp = rr; rdv = rd;
            @(posedge clk);
            if (ta) arv <= 1'b0;
            if (tr)
            begin
                rry <= 1'b0;
                return;
            end
        end
    endtask
    // trim outputs and status word against the expected register images
    task automatic chk_out();
        `CHK(mag, ofs_e[15:8])
        `CHK(neg, ofs_e[7])
        `CHK(gain, gn_e[15:7])
        rd_reg(TRIM_STATUS_ADDR);
        `CHK(rdv, {7'h00, gn_e[15:7], 7'h00, ofs_e[7], ofs_e[15:8]})
    endtask
    task automatic t_reset();
        `CHK({mag, neg, gain}, {8'h00, 1'b0, 9'h100})
        chk_out();
        rd_reg(OFFSET_TRIM_ADDR);
        `CHK({rsp, rdv}, {RESP_SLVERR, 32'h0000_0000})
        rd_reg(GAIN_TRIM_ADDR);
        `CHK({rsp, rdv}, {RESP_SLVERR, 32'h0000_0000})
        $display("test reset done");
    endtask
    task automatic t_trim();
        logic [15:0] ov[4] = '{16'hFFFF, 16'hFF7F, 16'h00FF, 16'h017F};
        logic [15:0] gv[5] = '{16'h007F, 16'hFFFF, 16'h207F, 16'hE07F, 16'h807F};
        foreach (ov[i])
        begin
            wr_reg(OFFSET_TRIM_ADDR, {16'h0000, ov[i]});
            ofs_e = ov[i];
            `CHK(rsp, RESP_OKAY)
            chk_out();
        end
        // successive gain writes, each checked after its write response has been taken
        foreach (gv[i])
        begin
            wr_reg(GAIN_TRIM_ADDR, {16'hA5A5, gv[i]});
            gn_e = gv[i];
            `CHK({rsp, gain, mag}, {RESP_OKAY, gv[i][15:7], ofs_e[15:8]})
        end
        // single byte lanes: lane 1 alone moves the magnitude, lane 0 alone the sign
        wr_reg(OFFSET_TRIM_ADDR, 32'h0000_AB7F, 4'h2);
        ofs_e[15:8] = 8'hAB;
        `CHK({rsp, mag, neg}, {RESP_OKAY, 8'hAB, 1'b0})
        wr_reg(OFFSET_TRIM_ADDR, 32'h0000_00FF, 4'h1);
        ofs_e[7:0] = 8'hFF;
        `CHK({rsp, mag, neg}, {RESP_OKAY, 8'hAB, 1'b1})
        chk_out();
        $display("test trim done");
    endtask
    task automatic t_bad();
        wr_reg(6'h14, 32'h0000_0000);
        `CHK(rsp, RESP_SLVERR)
        chk_out();
        rd_reg(6'h3C);
        `CHK(rsp, RESP_SLVERR)
        $display("test unmapped done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #200000;
        $display("[ERR] %0t watchdog expired", $time);
        fails++;
        test_done();
    end
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        t_reset();
        t_trim();
        t_bad();
        test_done();
    end
endmodule
